// ==== core/esc_echo_suppress.sv ====
`timescale 1ns/100ps
// Functional notes
// [RULE1] Noise guard select one: attenuate transmit only with far-end speech and no near-end.
// [RULE2] Noise guard select zero: attenuate transmit whenever near-end speech is absent.
// [RULE3] Noise guard select sits at bit 4 of configuration register 0.
// [RULE4] Register 3 bits 15:14 choose the transmit suppression loss.
// [RULE5] Register 3 bits 7:6 choose the expected echo return loss enhancement.
// [RULE6] Register 3 bits 5:4 bias how easily near-end speech releases suppression.
// [RULE7] Reset gives a 15 dB echo expectation and an 18 dB release bias.
// [RULE8] Controller should set bias above expectation, larger expectation at higher volume.
// [RULE9] Receive path is attenuated except while far-end speech is detected.
// [RULE10] Steady receive signals get attenuated once the noise estimate catches up.
// [RULE11] Register 2 bits 13:12 set the receive suppression detector threshold.
// [RULE12] During double-talk an optional loss applies to transmit, receive or both.
// [RULE13] Configuration port is strobe clock, serial data and active-low word done.
// [RULE14] Controller gives four strobe pulses after word done rises to latch.
// [RULE15] Engaged receive suppression applies a fixed 24 dB attenuation.
// [RULE16] A detector reports speech when power exceeds noise by its threshold.
// [RULE17] Settings change only from a fully latched word, never a partial one.
module esc_echo_suppress
  import esc_pkg::*;
(
  // Core clock and reset.
  input logic core_clk,
  input logic rst,
  // AXI4-Lite write address and data.
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read.
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Controller serial port.
  input logic strobe_clk,
  input logic serial_data,
  input logic word_done_n,
  // Power and noise estimates from the signal path.
  input esc_level_type tx_level,
  input esc_level_type rx_level,
  // Loss applied to each path.
  output logic [7:0] tx_loss_db,
  output logic [7:0] rx_loss_db,
  output logic tx_suppress_on,
  output logic rx_suppress_on,
  output logic double_talk
);

  function automatic logic [2:0] decode_index(input logic [7:0] addr);
    if (addr == OFS_CFG0) begin
      return 3'h0;
    end else if (addr == OFS_CFG1) begin
      return 3'h1;
    end else if (addr == OFS_CFG2) begin
      return 3'h2;
    end else if (addr == OFS_CFG3) begin
      return 3'h3;
    end else if (addr == OFS_DT) begin
      return IDX_DT;
    end else if (addr == OFS_STATUS) begin
      return IDX_STATUS;
    end else begin
      return IDX_NONE;
    end
  endfunction

  logic [NUM_CFG-1:0][15:0] cfg;
  logic [7:0] word_count;

  // Serial capture on the strobe clock.
  esc_word_type link_word;
  logic link_flag;
  logic flag_s1;
  logic flag_s2;
  logic flag_s3;
  logic flag_seen;
  logic word_event;

  esc_serial_rx u_serial_rx (
    .strobe_clk(strobe_clk),
    .serial_data(serial_data),
    .word_done_n(word_done_n),
    .word(link_word),
    .word_flag(link_flag)
  ); // [RULE13]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_s1 <= 1'b0;
      flag_s2 <= 1'b0;
      flag_s3 <= 1'b0;
    end else begin
      flag_s1 <= link_flag;
      flag_s2 <= flag_s1;
      flag_s3 <= flag_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_seen <= 1'b0;
    end else if (flag_s2 == flag_s3) begin
      flag_seen <= flag_s3;
    end
  end

  // The word is stable for many strobe periods once its flag has risen.
  assign word_event = (flag_s2 == flag_s3) && flag_s3 && !flag_seen; // [RULE17]

  // Write channel.
  logic aw_full;
  logic w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic write_do;
  logic [2:0] write_index;
  logic next_aw_full;
  logic next_w_full;

  assign write_do = aw_full && w_full && !s_axi_bvalid;
  assign write_index = decode_index(aw_addr);
  assign next_aw_full = (aw_full || (s_axi_awvalid && s_axi_awready)) && !write_do;
  assign next_w_full = (w_full || (s_axi_wvalid && s_axi_wready)) && !write_do;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready <= !next_w_full;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (write_index == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration storage; a serial word written in the same cycle wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= CFG_RST; // [RULE7]
    end else begin
      if (write_do && write_index <= IDX_DT) begin
        if (w_strb[0]) begin
          cfg[write_index][7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          cfg[write_index][15:8] <= w_data[15:8];
        end
      end
      if (word_event) begin
        cfg[link_word.index] <= link_word.value; // [RULE17]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_count <= 8'h00;
    end else if (word_event) begin
      word_count <= word_count + 8'h01;
    end
  end

  // Field extraction.
  logic noise_guard_select;
  logic [1:0] tx_suppress_loss;
  logic [1:0] echo_expectation_threshold;
  logic [1:0] release_bias;
  logic [1:0] rx_suppress_detect_threshold;
  logic dt_tx_enable;
  logic dt_rx_enable;
  logic [7:0] dt_loss_db;
  logic [7:0] echo_db;
  logic [7:0] bias_db;

  assign noise_guard_select = cfg[0][NGS_BIT]; // [RULE3]
  assign tx_suppress_loss = cfg[3][TX_LOSS_LSB +: 2]; // [RULE4]
  assign echo_expectation_threshold = cfg[3][ECHO_THR_LSB +: 2]; // [RULE5]
  assign release_bias = cfg[3][BIAS_LSB +: 2]; // [RULE6]
  assign rx_suppress_detect_threshold = cfg[2][RX_THR_LSB +: 2]; // [RULE11]
  assign dt_tx_enable = cfg[IDX_DT][DT_TX_BIT];
  assign dt_rx_enable = cfg[IDX_DT][DT_RX_BIT];
  assign dt_loss_db = esc_lookup(LOSS_DB_TABLE, cfg[IDX_DT][DT_LOSS_LSB +: 2]);
  assign echo_db = esc_lookup(ECHO_DB_TABLE, echo_expectation_threshold);
  assign bias_db = esc_lookup(BIAS_DB_TABLE, release_bias);

  // Speech detectors.
  logic tx_speech;
  logic far_speech;

  esc_speech_detect u_tx_detect (
    .core_clk(core_clk),
    .rst(rst),
    .level(tx_level),
    .threshold_code(TX_DETECT_CODE),
    .speech(tx_speech)
  );

  esc_speech_detect u_rx_detect (
    .core_clk(core_clk),
    .rst(rst),
    .level(rx_level),
    .threshold_code(rx_suppress_detect_threshold),
    .speech(far_speech)
  ); // [RULE11]

  // Near-end decision: microphone power above the expected echo level.
  esc_near_state_type near_state;
  esc_near_state_type next_near_state;
  logic near_start;
  logic near_keep;
  logic near_speech;

  assign near_start = tx_speech && ({1'b0, tx_level.power} + {1'b0, echo_db} > {1'b0, rx_level.power}); // [RULE5]
  assign near_keep = tx_speech && ({1'b0, tx_level.power} + {1'b0, bias_db} > {1'b0, rx_level.power}); // [RULE6]
  assign near_speech = near_state == NEAR_ACTIVE;

  always_comb begin
    next_near_state = near_state;
    case (near_state)
      NEAR_IDLE: begin
        if (near_start) begin
          next_near_state = NEAR_ACTIVE;
        end
      end
      NEAR_ACTIVE: begin
        if (!near_keep) begin
          next_near_state = NEAR_IDLE;
        end
      end
      default: begin
        next_near_state = NEAR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      near_state <= NEAR_IDLE;
    end else begin
      near_state <= next_near_state;
    end
  end

  // Suppression decisions and applied loss.
  logic next_tx_on;
  logic next_rx_on;
  logic next_double_talk;
  logic [7:0] next_tx_loss;
  logic [7:0] next_rx_loss;

  always_comb begin
    if (noise_guard_select) begin
      next_tx_on = far_speech && !near_speech; // [RULE1]
    end else begin
      next_tx_on = !near_speech; // [RULE2]
    end
    next_rx_on = !far_speech; // [RULE9] [RULE10]
    next_double_talk = far_speech && near_speech;
    next_tx_loss = (next_tx_on ? esc_lookup(LOSS_DB_TABLE, tx_suppress_loss) : 8'h00)
      + ((next_double_talk && dt_tx_enable) ? dt_loss_db : 8'h00); // [RULE4] [RULE12]
    next_rx_loss = (next_rx_on ? RX_SUPPRESS_DB : 8'h00)
      + ((next_double_talk && dt_rx_enable) ? dt_loss_db : 8'h00); // [RULE15] [RULE12]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_suppress_on <= 1'b0;
      rx_suppress_on <= 1'b0;
      double_talk <= 1'b0;
      tx_loss_db <= 8'h00;
      rx_loss_db <= 8'h00;
    end else begin
      tx_suppress_on <= next_tx_on;
      rx_suppress_on <= next_rx_on;
      double_talk <= next_double_talk;
      tx_loss_db <= next_tx_loss;
      rx_loss_db <= next_rx_loss;
    end
  end

  // Read channel.
  logic [2:0] read_index;
  logic [15:0] status;
  logic [15:0] read_value;

  assign read_index = decode_index(s_axi_araddr);
  assign status = {word_count, 3'h0, double_talk, rx_suppress_on, tx_suppress_on, near_speech, far_speech};

  always_comb begin
    if (read_index == IDX_STATUS) begin
      read_value = status;
    end else if (read_index <= IDX_DT) begin
      read_value = cfg[read_index];
    end else begin
      read_value = 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, read_value};
      s_axi_rresp <= (read_index == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== core/esc_pkg.sv ====
package esc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CFG2 = 8'h08;
  localparam logic [7:0] OFS_CFG3 = 8'h0c;
  localparam logic [7:0] OFS_DT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Register indices used by the decoder; the two-bit serial word index reaches only 0 to 3.
  localparam logic [2:0] IDX_DT = 3'h4;
  localparam logic [2:0] IDX_STATUS = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam int NUM_CFG = 5;

  // Field positions.
  localparam int NGS_BIT = 4;
  localparam int RX_THR_LSB = 12;
  localparam int TX_LOSS_LSB = 14;
  localparam int ECHO_THR_LSB = 6;
  localparam int BIAS_LSB = 4;
  localparam int DT_TX_BIT = 0;
  localparam int DT_RX_BIT = 1;
  localparam int DT_LOSS_LSB = 4;
  localparam int STAT_COUNT_LSB = 8;

  // Values after reset.
  localparam logic [15:0] CFG0_RST = 16'h0010;
  localparam logic [15:0] CFG1_RST = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h1000;
  localparam logic [15:0] CFG3_RST = 16'h40a0;
  localparam logic [15:0] DT_RST = 16'h0010;
  localparam logic [NUM_CFG-1:0][15:0] CFG_RST = {DT_RST, CFG3_RST, CFG2_RST, CFG1_RST, CFG0_RST};

  // Level tables in dB, indexed by a two-bit code.
  localparam logic [3:0][7:0] DETECT_DB_TABLE = {8'h0c, 8'h09, 8'h06, 8'h03};
  localparam logic [3:0][7:0] ECHO_DB_TABLE = {8'h12, 8'h0f, 8'h0c, 8'h09};
  localparam logic [3:0][7:0] BIAS_DB_TABLE = {8'h15, 8'h12, 8'h0f, 8'h0c};
  localparam logic [3:0][7:0] LOSS_DB_TABLE = {8'h18, 8'h12, 8'h0c, 8'h06};
  localparam logic [1:0] TX_DETECT_CODE = 2'h1;
  localparam logic [7:0] RX_SUPPRESS_DB = 8'h18;

  // Serial word: two index bits then sixteen value bits, first bit first.
  localparam int WORD_BITS = 18;
  localparam logic [2:0] LATCH_CLOCKS = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] power;
    logic [7:0] noise;
  } esc_level_type;

  typedef struct packed {
    logic [1:0] index;
    logic [15:0] value;
  } esc_word_type;

  typedef enum logic {NEAR_IDLE, NEAR_ACTIVE} esc_near_state_type;

  function automatic logic [7:0] esc_lookup(input logic [3:0][7:0] table_db, input logic [1:0] code);
    return table_db[code];
  endfunction

endpackage

// ==== core/esc_serial_rx.sv ====
`timescale 1ns/100ps
module esc_serial_rx
  import esc_pkg::*;
(
  // Controller pins, all sampled on the strobe clock.
  input logic strobe_clk,
  input logic serial_data,
  input logic word_done_n,
  // Latched word and its ready level.
  output esc_word_type word,
  output logic word_flag
);

  logic [WORD_BITS-1:0] shift;
  logic [2:0] extra_cnt;

  always_ff @(posedge strobe_clk) begin
    if (!word_done_n) begin
      shift <= {shift[WORD_BITS-2:0], serial_data};
    end
  end

  // Counting restarts with every frame, so the strobe domain needs no reset.
  always_ff @(posedge strobe_clk) begin
    if (!word_done_n) begin
      extra_cnt <= 3'h0;
    end else if (extra_cnt != LATCH_CLOCKS) begin
      extra_cnt <= extra_cnt + 3'h1;
    end
  end

  always_ff @(posedge strobe_clk) begin
    if (word_done_n && extra_cnt == LATCH_CLOCKS - 3'h1) begin
      word <= shift; // [RULE14]
    end
  end

  // The level falls at frame start and rises when the word is latched.
  always_ff @(posedge strobe_clk) begin
    if (!word_done_n) begin
      word_flag <= 1'b0;
    end else if (extra_cnt == LATCH_CLOCKS - 3'h1) begin
      word_flag <= 1'b1; // [RULE17]
    end
  end

endmodule

// ==== core/esc_speech_detect.sv ====
`timescale 1ns/100ps
module esc_speech_detect
  import esc_pkg::*;
(
  // Clock and reset.
  input logic core_clk,
  input logic rst,
  // Power estimate, tracked noise and threshold code.
  input esc_level_type level,
  input logic [1:0] threshold_code,
  // Detector result.
  output logic speech
);

  logic [8:0] limit;

  assign limit = {1'b0, level.noise} + {1'b0, esc_lookup(DETECT_DB_TABLE, threshold_code)};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      speech <= 1'b0;
    end else begin
      speech <= {1'b0, level.power} > limit; // [RULE16] [RULE10]
    end
  end

endmodule

// ==== bench/esc_echo_suppress_asserts.sv ====
`timescale 1ns/100ps
module esc_echo_suppress_asserts
  import esc_pkg::*;
(
  // Clock and reset.
  input logic core_clk,
  input logic rst,
  // Bus handshakes.
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  // Levels and suppression outputs.
  input esc_level_type tx_level,
  input esc_level_type rx_level,
  input logic [7:0] tx_loss_db,
  input logic [7:0] rx_loss_db,
  input logic tx_suppress_on,
  input logic rx_suppress_on,
  input logic double_talk
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Margins clear every selectable detector threshold.
  logic far_loud;
  logic far_quiet;
  logic near_quiet;
  assign far_loud = {1'h0, rx_level.power} > {1'h0, rx_level.noise} + 9'h00c;
  assign far_quiet = rx_level.power <= rx_level.noise;
  assign near_quiet = tx_level.power <= tx_level.noise;

  rx_open_a: assert property (far_loud [*4] |-> !rx_suppress_on)
    else $error("rx suppressed during far speech");
  rx_shut_a: assert property (far_quiet [*4] |-> rx_suppress_on)
    else $error("rx open without far speech");
  rx_loss_a: assert property (rx_suppress_on |-> rx_loss_db == RX_SUPPRESS_DB)
    else $error("rx suppression loss wrong");
  tx_engage_a: assert property ((near_quiet && far_loud) [*4] |-> tx_suppress_on)
    else $error("tx not suppressed with far speech only");
  tx_loss_a: assert property (tx_suppress_on |-> tx_loss_db inside {8'h06, 8'h0c, 8'h12, 8'h18})
    else $error("tx suppression loss off table");
  dt_excl_a: assert property (double_talk |-> !tx_suppress_on && !rx_suppress_on)
    else $error("suppression active in double talk");
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");

  cover property (tx_suppress_on);
  cover property (double_talk);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

// ==== bench/esc_ctrl_model.sv ====
`timescale 1ns/100ps
module esc_ctrl_model (
  // Serial configuration pins.
  output logic strobe_clk,
  output logic serial_data,
  output logic word_done_n
);
  initial begin
    strobe_clk = 1'h0;
    serial_data = 1'h0;
    word_done_n = 1'h1;
  end
  // The strobe stands still between frames; data shows the inverse of the last bit once released.
  task automatic send(input logic [17:0] word, input int extra);
    for (int i = 17; i >= 0; i--) begin
      word_done_n = 1'h0;
      serial_data = word[i];
      #24 strobe_clk = 1'h1;
      #24 strobe_clk = 1'h0;
    end
    word_done_n = 1'h1;
    serial_data = ~word[0];
    for (int i = 0; i < extra; i++) begin
      #24 strobe_clk = 1'h1;
      #24 strobe_clk = 1'h0;
    end
    #250;
  endtask
endmodule

// ==== bench/esc_echo_suppress_tb_top.sv ====
`timescale 1ns/100ps
module esc_echo_suppress_tb_top
  import esc_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  esc_level_type tx_level = 16'h0a0a;
  esc_level_type rx_level = 16'h0a0a;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic strobe_clk, serial_data, word_done_n;
  logic [7:0] tx_loss_db, rx_loss_db;
  logic tx_suppress_on, rx_suppress_on, double_talk;
  int num_errors = 0;
  int samples_checked = 0;

  always #25 core_clk = ~core_clk;

  esc_echo_suppress dut (.*);
  esc_ctrl_model ctrl (.*);

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 40);
    s_axi_bready <= 1'h0;
    check("bvalid", 32'h1, s_axi_bvalid);
    check("bresp", er, s_axi_bresp);
    // One idle edge keeps the next call from reassigning the handshake in this time step.
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 40);
    s_axi_rready <= 1'h0;
    check("rvalid", 32'h1, s_axi_rvalid);
    check("rdata", {16'h0000, ed}, s_axi_rdata);
    check("rresp", er, s_axi_rresp);
    @(posedge core_clk);
  endtask

  // Levels are tx power, tx noise, rx power, rx noise; losses are tx then rx; flags are tx on, rx on.
  task automatic lv(input logic [31:0] lvl, input logic [15:0] loss, input logic [1:0] f);
    {tx_level, rx_level} <= lvl;
    repeat (5) @(posedge core_clk);
    check("tx_loss_db", loss[15:8], tx_loss_db);
    check("rx_loss_db", loss[7:0], rx_loss_db);
    check("suppress", f, {tx_suppress_on, rx_suppress_on});
  endtask

  task automatic t_reset;
    rd(OFS_CFG0, CFG0_RST, RESP_OKAY);
    rd(OFS_CFG2, CFG2_RST, RESP_OKAY);
    rd(OFS_CFG3, 16'h40a0, RESP_OKAY);
    rd(8'h18, 16'h0000, RESP_SLVERR);
    wr(8'h18, 16'hffff, RESP_SLVERR);
    wr(OFS_STATUS, 16'hffff, RESP_OKAY);
    $display("test reset done");
  endtask

  task automatic t_rx;
    lv(32'h0a0a1414, 16'h0018, 2'h1);
    lv(32'h0a0a1b14, 16'h0c00, 2'h2);
    wr(OFS_CFG2, 16'h3000, RESP_OKAY);
    lv(32'h0a0a1b14, 16'h0018, 2'h1);
    lv(32'h0a0a2814, 16'h0c00, 2'h2);
    lv(32'h0a0a2823, 16'h0018, 2'h1);
    wr(OFS_CFG2, 16'h1000, RESP_OKAY);
    $display("test rx done");
  endtask

  task automatic t_tx;
    lv(32'h0a0a0a0a, 16'h0018, 2'h1);
    wr(OFS_CFG0, 16'h0000, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CFG3, {2'(c), 14'h00a0}, RESP_OKAY);
      lv(32'h0a0a0a0a, {LOSS_DB_TABLE[c], 8'h18}, 2'h3);
    end
    wr(OFS_CFG3, 16'h40a0, RESP_OKAY);
    wr(OFS_CFG0, 16'h0010, RESP_OKAY);
    lv(32'h0a0a0a0a, 16'h0018, 2'h1);
    $display("test tx done");
  endtask

  task automatic t_near;
    lv(32'h320a3c0a, 16'h0000, 2'h0);
    lv(32'h2c0a3c0a, 16'h0000, 2'h0);
    wr(OFS_CFG3, 16'h4080, RESP_OKAY);
    lv(32'h2c0a3c0a, 16'h0c00, 2'h2);
    wr(OFS_CFG3, 16'h4000, RESP_OKAY);
    lv(32'h320a3c0a, 16'h0c00, 2'h2);
    wr(OFS_CFG3, 16'h40a0, RESP_OKAY);
    lv(32'h320a3c0a, 16'h0000, 2'h0);
    $display("test near done");
  endtask

  task automatic t_dt;
    for (int c = 1; c < 4; c++) begin
      wr(OFS_DT, {12'h001, 2'h0, 2'(c)}, RESP_OKAY);
      lv(32'h320a3c0a, {(c[0] ? 8'h0c : 8'h00), (c[1] ? 8'h0c : 8'h00)}, 2'h0);
      check("double_talk", 32'h1, double_talk);
    end
    wr(OFS_DT, DT_RST, RESP_OKAY);
    $display("test double talk done");
  endtask

  task automatic t_serial;
    ctrl.send({2'h3, 16'hc0a0}, 4);
    repeat (8) @(posedge core_clk);
    rd(OFS_CFG3, 16'hc0a0, RESP_OKAY);
    ctrl.send({2'h3, 16'h40a0}, 3);
    repeat (8) @(posedge core_clk);
    rd(OFS_CFG3, 16'hc0a0, RESP_OKAY);
    ctrl.send({2'h3, 16'h40a0}, 4);
    repeat (8) @(posedge core_clk);
    rd(OFS_CFG3, 16'h40a0, RESP_OKAY);
    // Two complete words counted, far and near speech with double talk, both suppressors off.
    rd(OFS_STATUS, 16'h0213, RESP_OKAY);
    $display("test serial done");
  endtask

  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    t_reset;
    t_rx;
    t_tx;
    t_near;
    t_dt;
    t_serial;
    end_sim;
  end

  // The whole sequence needs well under a tenth of this span.
  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
endmodule

bind esc_echo_suppress esc_echo_suppress_asserts chk (.*);
